// *** design/pmev_regs.v ***
// Purpose: Event enable, NMI flag and suspend mirror registers
// Assumes: Host I/O cycle: address, read and write strobes, 16-bit data
// Notes:   Mirror inputs come from the serial, parallel, IRQ and activity timeout logic
`timescale 1ns/100ps
`include "pmev_consts.vh"
module pmev_regs #(
   parameter NIN = 6            // Event inputs, numbered 2 upward
) (
   input  wire        CLK_I,          // System clock
   input  wire        RESETN_I,       // Asynchronous reset, active low
   input  wire [15:0] IO_ADDR_I,      // Host I/O port address
   input  wire        IO_WR_I,        // Write strobe, one cycle
   input  wire        IO_RD_I,        // Read strobe, one cycle
   input  wire [15:0] IO_WDATA_I,     // Write data
   output wire [15:0] IO_RDATA_O,     // Read data, valid cycle after read
   input  wire [NIN-1:0] POWER_MGMT_IN_I, // Event inputs 7..2
   output wire [NIN-1:0] INPUT_STATUS_O,  // Input status 7..2
   output wire        NMI_O,          // NMI request pulse
   output wire        LOCAL_ATTENTION_OUT_O, // Attention, output 4
   input  wire [1:0]  SERIAL_A_MIRROR_I,     // Serial A reg2 bits 7:6
   input  wire [1:0]  SERIAL_B_MIRROR_I,     // Serial B reg2 bits 7:6
   input  wire [3:0]  PARALLEL_REG2_MIRROR_I, // Parallel reg2 bits 3:0
   input  wire [7:0]  PARALLEL_REG0_MIRROR_I, // Parallel reg0
   input  wire        ACTIVITY_TIMEOUT_COMPARE_I, // Timeout comparator
   input  wire        MASTER_VECTOR_BIT7_I,  // Master ICW2 bit 7
   input  wire        SLAVE_VECTOR_BIT7_I,   // Slave ICW2 bit 7
   input  wire        FULLY_NESTED_SELECT_I, // Master ICW4 bit 4
   input  wire        AUTO_EOI_SELECT_I,     // Master ICW4 bit 1
   input  wire [2:0]  MASTER_OCW2_CMD_I,     // Master last OCW2 bits 7:5
   input  wire [2:0]  MASTER_BOTTOM_PRIORITY_I, // Master OCW2 level
   input  wire [2:0]  SLAVE_BOTTOM_PRIORITY_I,  // Slave OCW2 level
   input  wire        MASTER_SPECIAL_MASK_I, // Master OCW3 special mask
   input  wire        SLAVE_SPECIAL_MASK_I   // Slave OCW3 special mask
);
   // Rotate-on-auto-EOI set command code (OCW2 bits 7:5)
   localparam [2:0] ROT_AEOI_SET = 3'h4;
   localparam [2:0] ROT_AEOI_CLR = 3'h0;
   // Enable register reset image, sliced per field below
   localparam [15:0] EN_RST = `PMEV_ENABLE_RESET;

   reg  [NIN-1:0] nmi_change_enable_q; // Enable bits 15:10
   reg  [NIN-1:0] attention_enable_q;  // Enable bits 7:2
   reg  [15:0]    rdata_q;             // Registered read data
   reg            nmi_q;               // NMI output
   reg            atn_q;               // Attention output
   reg  [NIN-1:0] status_q;            // Registered status
   reg            rot_aeoi_q;          // Rotate auto EOI selected
   reg  [15:0]    rdata_d;             // Read mux
   wire [NIN-1:0] nmi_source_flag;     // Per-input NMI flags
   wire [NIN-1:0] atn_flag;            // Per-input attention flags
   wire [NIN-1:0] nmi_req;             // Per-input NMI requests
   wire [NIN-1:0] input_status;        // Per-input status

   genvar k;
   // One cell per input
   generate
      for (k = 0; k < NIN; k = k + 1) begin : g_in
         pmev_input_cell u_cell (
            .clk_i      (CLK_I),
            .resetn_i   (RESETN_I),
            .level_i    (POWER_MGMT_IN_I[k]),
            .nmi_en_i   (nmi_change_enable_q[k]),
            .atn_en_i   (attention_enable_q[k]),
            .status_o   (input_status[k]),
            .nmi_flag_o (nmi_source_flag[k]),
            .atn_flag_o (atn_flag[k]),
            .nmi_req_o  (nmi_req[k])
         );
      end
   endgenerate

   // Enable register write; bits 9:8 and 1:0 dropped
   always @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         nmi_change_enable_q <= EN_RST[`PMEV_NMI_EN_LSB +: NIN];
         attention_enable_q  <= EN_RST[`PMEV_ATN_EN_LSB +: NIN];
      end else if (IO_WR_I && IO_ADDR_I == `PMEV_ADDR_ENABLE) begin
         nmi_change_enable_q <=
            IO_WDATA_I[`PMEV_NMI_EN_LSB +: NIN];
         attention_enable_q  <=
            IO_WDATA_I[`PMEV_ATN_EN_LSB +: NIN];
      end
   end

   // Rotate-on-auto-EOI tracking from master OCW2 command
   always @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         rot_aeoi_q <= 1'b0;
      end else if (MASTER_OCW2_CMD_I == ROT_AEOI_SET) begin
         rot_aeoi_q <= 1'b1;
      end else if (MASTER_OCW2_CMD_I == ROT_AEOI_CLR) begin
         rot_aeoi_q <= 1'b0;
      end
   end

   // Read mux; mirrors are read-only, writes never reach them
   always @* begin
      rdata_d = 16'h0000;
      case (IO_ADDR_I)
         `PMEV_ADDR_FLAGS: begin
            // Upper byte and bits 1:0 stay zero
            rdata_d[`PMEV_FLAG_LSB +: NIN] = nmi_source_flag;
         end
         `PMEV_ADDR_ENABLE: begin
            rdata_d[`PMEV_NMI_EN_LSB +: NIN] = nmi_change_enable_q;
            rdata_d[`PMEV_ATN_EN_LSB +: NIN] = attention_enable_q;
         end
         `PMEV_ADDR_SPMIRROR: begin
            rdata_d = {SERIAL_A_MIRROR_I,
                       SERIAL_B_MIRROR_I,
                       PARALLEL_REG2_MIRROR_I,
                       PARALLEL_REG0_MIRROR_I};
         end
         `PMEV_ADDR_ICMIRROR: begin
            rdata_d = {ACTIVITY_TIMEOUT_COMPARE_I,
                       `PMEV_DEVICE_ID,
                       MASTER_VECTOR_BIT7_I,
                       SLAVE_VECTOR_BIT7_I,
                       FULLY_NESTED_SELECT_I,
                       AUTO_EOI_SELECT_I,
                       rot_aeoi_q,
                       MASTER_BOTTOM_PRIORITY_I,
                       SLAVE_BOTTOM_PRIORITY_I,
                       MASTER_SPECIAL_MASK_I,
                       SLAVE_SPECIAL_MASK_I};
         end
         default: begin
            rdata_d = 16'h0000; // Unmapped reads zero
         end
      endcase
   end

   // Output flops
   always @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         rdata_q  <= 16'h0000;
         nmi_q    <= 1'b0;
         atn_q    <= 1'b0;
         status_q <= {NIN{1'b0}};
      end else begin
         if (IO_RD_I) begin
            rdata_q <= rdata_d;
         end
         nmi_q    <= |nmi_req;
         atn_q    <= |(atn_flag & attention_enable_q);
         status_q <= input_status;
      end
   end

   assign IO_RDATA_O            = rdata_q;
   assign NMI_O                 = nmi_q;
   assign LOCAL_ATTENTION_OUT_O = atn_q;
   assign INPUT_STATUS_O        = status_q;
endmodule

// *** design/pmev_consts.vh ***
// Purpose: Constants for the power-management event and mirror registers
// Assumes: 16-bit host I/O register port, one clock
// Notes:   Offsets are the host I/O port addresses
// What this block does
// - Enabled input change raises NMI request
// - Enable bits 9 and 8 ignore writes
// - Attention enable lets input assert attention output
// - Enable bits 1 and 0 ignore writes
// - Flag bits 15-8 read zero
// - Flag set when input caused NMI; reset zero
// - Flag and status clear only via enable clear
// - Both enables set: clear needs both cleared
// - Flag bits 1 and 0 read zero
// - Mirror bits 15-14 show serial A bits 7-6
// - Mirror bits 13-12 show serial B bits 7-6
// - Mirror bits 11-8 show parallel reg2 bits 3-0
// - Mirror bits 7-0 show parallel reg0
// - Controller mirror bit 15 is timeout comparator
// - Controller mirror bits 14-13 fixed device id
// - Bit 12 is master vector bit 7
// - Bit 11 is slave vector bit 7
// - Bit 10 is master fully nested select
// - Bit 9 is master auto end-of-interrupt
// - Bit 8 is master rotate-on-auto-EOI selected
// - Bits 7-5 master bottom priority level
// - Bits 4-2 slave bottom priority level
// - Bits 1,0 master and slave special mask
// - Status live when disabled; when enabled, live until the first change, then latched
`ifndef PMEV_CONSTS_VH
`define PMEV_CONSTS_VH
`define PMEV_ADDR_FLAGS    16'h9072
`define PMEV_ADDR_ENABLE   16'hc872
`define PMEV_ADDR_SPMIRROR 16'hd072
`define PMEV_ADDR_ICMIRROR 16'hd472
`define PMEV_NMI_EN_LSB    10
`define PMEV_ATN_EN_LSB    2
`define PMEV_FLAG_LSB      2
`define PMEV_ENABLE_RESET  16'h0000
`define PMEV_FLAGS_RESET   6'h00
`define PMEV_DEVICE_ID     2'h0
`endif

// *** design/pmev_input_cell.v ***
// Purpose: One power-management input: status, NMI flag, attention flag
// Assumes: Input level synchronous to CLK_I
// Notes:   Status is live while both enables are clear
`timescale 1ns/100ps
module pmev_input_cell (
   input  wire clk_i,      // System clock
   input  wire resetn_i,   // Asynchronous reset, active low
   input  wire level_i,    // Input pin level
   input  wire nmi_en_i,   // NMI on change enable
   input  wire atn_en_i,   // Attention enable
   output wire status_o,   // Input status bit
   output wire nmi_flag_o, // Input caused NMI
   output wire atn_flag_o, // Input caused attention
   output wire nmi_req_o   // One-cycle NMI request pulse
);
   reg  prev_q;            // Level of previous cycle
   reg  latched_q;         // Status latched once change seen
   reg  stat_q;            // Latched status value
   reg  nmi_flag_q;        // Sticky NMI flag
   reg  atn_flag_q;        // Sticky attention flag
   wire any_en;            // Either enable set
   wire change;            // Change of state this cycle

   assign any_en = nmi_en_i | atn_en_i;
   assign change = level_i ^ prev_q;

   // Edge detect, latch and sticky flags
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         prev_q     <= 1'b0;
         latched_q  <= 1'b0;
         stat_q     <= 1'b0;
         nmi_flag_q <= 1'b0;
         atn_flag_q <= 1'b0;
      end else begin
         prev_q <= level_i;
         if (!any_en) begin
            // Both enables clear: flags and latch released
            latched_q  <= 1'b0;
            stat_q     <= 1'b0;
            nmi_flag_q <= 1'b0;
            atn_flag_q <= 1'b0;
         end else if (change && !latched_q) begin
            // First transition is latched
            latched_q <= 1'b1;
            stat_q    <= level_i;
         end
         if (any_en && change && nmi_en_i) begin
            nmi_flag_q <= 1'b1;
         end
         if (any_en && change && atn_en_i) begin
            atn_flag_q <= 1'b1;
         end
      end
   end

   // Live level until latched
   assign status_o   = latched_q ? stat_q : level_i;
   assign nmi_flag_o = nmi_flag_q;
   assign atn_flag_o = atn_flag_q;
   assign nmi_req_o  = change & nmi_en_i;
endmodule

// *** testbench/pmev_checker.sv ***
// Purpose: Port-level checks for the event and mirror registers
// Assumes: Read data appears one cycle after the read edge
// Notes:   Keeps its own copy of the writable enable bits
`timescale 1ns/100ps
`include "pmev_consts.vh"
module pmev_checker #(
   parameter NIN = 6
) (
   input wire CLK_I, RESETN_I, IO_WR_I, IO_RD_I, NMI_O,
   input wire LOCAL_ATTENTION_OUT_O, ACTIVITY_TIMEOUT_COMPARE_I,
   input wire MASTER_VECTOR_BIT7_I, SLAVE_VECTOR_BIT7_I,
   input wire FULLY_NESTED_SELECT_I, AUTO_EOI_SELECT_I,
   input wire MASTER_SPECIAL_MASK_I, SLAVE_SPECIAL_MASK_I,
   input wire [15:0] IO_ADDR_I, IO_WDATA_I, IO_RDATA_O,
   input wire [NIN-1:0] POWER_MGMT_IN_I, INPUT_STATUS_O,
   input wire [1:0] SERIAL_A_MIRROR_I, SERIAL_B_MIRROR_I,
   input wire [3:0] PARALLEL_REG2_MIRROR_I,
   input wire [7:0] PARALLEL_REG0_MIRROR_I,
   input wire [2:0] MASTER_BOTTOM_PRIORITY_I, SLAVE_BOTTOM_PRIORITY_I
);
   reg  [15:0] en_q;                                 // Writable enable bits
   wire [5:0]  en_any = en_q[15:10] | en_q[7:2];     // Either enable set
   wire [15:0] sp_w = {SERIAL_A_MIRROR_I, SERIAL_B_MIRROR_I,
                       PARALLEL_REG2_MIRROR_I, PARALLEL_REG0_MIRROR_I};
   wire [15:0] ic_w = {ACTIVITY_TIMEOUT_COMPARE_I, `PMEV_DEVICE_ID,
                       MASTER_VECTOR_BIT7_I, SLAVE_VECTOR_BIT7_I,
                       FULLY_NESTED_SELECT_I, AUTO_EOI_SELECT_I, 1'b0,
                       MASTER_BOTTOM_PRIORITY_I, SLAVE_BOTTOM_PRIORITY_I,
                       MASTER_SPECIAL_MASK_I, SLAVE_SPECIAL_MASK_I};
   reg  [NIN-1:0] pin_q;                             // Input levels, last edge
   wire [NIN-1:0] chg = POWER_MGMT_IN_I ^ pin_q;     // Input change this cycle
   // Previous-cycle input levels for change detection
   always @(posedge CLK_I) begin
      pin_q <= POWER_MGMT_IN_I;
   end
   // Track host writes to the enable register, unused bits dropped
   always @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         en_q <= 16'h0000;
      end else if (IO_WR_I && IO_ADDR_I == `PMEV_ADDR_ENABLE) begin
         en_q <= IO_WDATA_I & 16'hfcfc;
      end
   end
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RESETN_I);
   sp_mirror_a: assert property (IO_RD_I && IO_ADDR_I == 16'hd072
      |=> IO_RDATA_O == $past(sp_w)) else $error("serial mirror");
   ic_mirror_a: assert property (IO_RD_I && IO_ADDR_I == 16'hd472
      |=> (IO_RDATA_O & 16'hfeff) == $past(ic_w)) else $error("ic mirror");
   en_read_a: assert property (IO_RD_I && IO_ADDR_I == 16'hc872
      |=> IO_RDATA_O == $past(en_q)) else $error("enable readback");
   flag_zero_a: assert property (IO_RD_I && IO_ADDR_I == 16'h9072
      |=> IO_RDATA_O[15:8] == 8'h00 && IO_RDATA_O[1:0] == 2'h0)
      else $error("flag unused bits");
   flag_clear_a: assert property (IO_RD_I && IO_ADDR_I == 16'h9072
      |=> (IO_RDATA_O[7:2] & ~($past(en_any) | $past(en_any, 2)
      | $past(en_any, 3))) == 6'h00) else $error("flag without enable");
   status_live_a: assert property (((INPUT_STATUS_O ^ $past(POWER_MGMT_IN_I))
      & ~(en_any | $past(en_any) | $past(en_any, 2) | $past(en_any, 3)))
      == 6'h00) else $error("status not live");
   nmi_raise_a: assert property ((chg & en_q[15:10] & $past(en_q[15:10]))
      != 6'h00 |-> ##[0:2] NMI_O) else $error("missing nmi");
   nmi_cause_a: assert property (NMI_O |-> (en_q[15:10]
      | $past(en_q[15:10])) != 6'h00) else $error("nmi without enable");
   atn_raise_a: assert property ((chg & en_q[7:2] & $past(en_q[7:2]))
      != 6'h00 |-> ##[0:3] LOCAL_ATTENTION_OUT_O) else $error("no atn");
   atn_cause_a: assert property (LOCAL_ATTENTION_OUT_O |-> (en_q[7:2]
      | $past(en_q[7:2])) != 6'h00) else $error("atn without enable");
endmodule
bind pmev_regs pmev_checker #(.NIN(NIN)) u_checker (.*);

// *** testbench/pmev_regs_tb_top.sv ***
// Purpose: Self-checking bench for the event and mirror registers
// Assumes: Strobes one cycle wide, driven on falling edges
// Notes:   Mirror inputs all ones on the first pass, then from a fixed-seed xorshift
`timescale 1ns/100ps
`include "pmev_consts.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
 $display("[FAIL] %0t got %h want %h", $time, g, e); end end
module pmev_regs_tb_top;
   reg CLK_I = 1'b0, RESETN_I = 1'b0, IO_WR_I = 1'b0, IO_RD_I = 1'b0;
   reg [15:0] IO_ADDR_I = '0, IO_WDATA_I = '0;
   reg [5:0] pin = '0;                    // Event input levels
   reg [28:0] m = '0;                     // Mirror input bundle
   reg [2:0] cmd = '0;                    // Master OCW2 command field
   reg [31:0] seed = 32'hd8a28cdf;
   integer nmi_cnt = 0, n0 = 0;           // NMI pulses counted, snapshot
   reg rot = 1'b0;                        // Expected rotate bit
   wire [15:0] rdata;
   wire [5:0] status;
   wire nmi, atn;
   integer n_mismatch = 0, checks = 0, k;
   pmev_regs #(.NIN(6)) dut (.CLK_I(CLK_I), .RESETN_I(RESETN_I),
      .IO_ADDR_I(IO_ADDR_I), .IO_WR_I(IO_WR_I), .IO_RD_I(IO_RD_I),
      .IO_WDATA_I(IO_WDATA_I), .IO_RDATA_O(rdata),
      .POWER_MGMT_IN_I(pin), .INPUT_STATUS_O(status), .NMI_O(nmi),
      .LOCAL_ATTENTION_OUT_O(atn), .SERIAL_A_MIRROR_I(m[28:27]),
      .SERIAL_B_MIRROR_I(m[26:25]), .PARALLEL_REG2_MIRROR_I(m[24:21]),
      .PARALLEL_REG0_MIRROR_I(m[20:13]), .ACTIVITY_TIMEOUT_COMPARE_I(m[12]),
      .MASTER_VECTOR_BIT7_I(m[11]), .SLAVE_VECTOR_BIT7_I(m[10]),
      .FULLY_NESTED_SELECT_I(m[9]), .AUTO_EOI_SELECT_I(m[8]),
      .MASTER_OCW2_CMD_I(cmd), .MASTER_BOTTOM_PRIORITY_I(m[7:5]),
      .SLAVE_BOTTOM_PRIORITY_I(m[4:2]), .MASTER_SPECIAL_MASK_I(m[1]),
      .SLAVE_SPECIAL_MASK_I(m[0]));
   always #4 CLK_I = ~CLK_I;
   // Count the one-cycle NMI pulses
   always @(posedge CLK_I) if (nmi === 1'b1) nmi_cnt <= nmi_cnt + 1;
   function [31:0] xs(input [31:0] x);
      reg [31:0] y;
      begin
         y = x ^ (x << 13); y = y ^ (y >> 17); xs = y ^ (y << 5);
      end
   endfunction
   // Expected controller mirror; rotate bit tracked by the bench
   function [15:0] exp_ic(input [28:0] v, input r);
      exp_ic = {v[12], `PMEV_DEVICE_ID, v[11:8], r, v[7:0]};
   endfunction
   task wr(input [15:0] a, input [15:0] d);
      begin
         @(negedge CLK_I); IO_ADDR_I = a; IO_WDATA_I = d; IO_WR_I = 1'b1;
         @(negedge CLK_I); IO_WR_I = 1'b0;
      end
   endtask
   task rd(input [15:0] a, input [15:0] e);
      begin
         @(negedge CLK_I); IO_ADDR_I = a; IO_RD_I = 1'b1;
         @(negedge CLK_I); IO_RD_I = 1'b0;
         @(negedge CLK_I); `CHK(rdata, e)
      end
   endtask
   task stop_test;
      begin
         $display("checks %0d mismatches %0d", checks, n_mismatch);
         if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
         else $display("STATUS NOT OK");
         $finish;
      end
   endtask
   initial begin
      #100000; n_mismatch++; stop_test;
   end
   initial begin
      repeat (5) @(negedge CLK_I); RESETN_I = 1'b1;
      rd(`PMEV_ADDR_ENABLE, 16'h0000);
      rd(`PMEV_ADDR_FLAGS, 16'h0000);
      rd(16'h1234, 16'h0000);
      wr(`PMEV_ADDR_ENABLE, 16'hffff);
      rd(`PMEV_ADDR_ENABLE, 16'hfcfc);
      wr(`PMEV_ADDR_ENABLE, 16'h0000);
      wr(`PMEV_ADDR_FLAGS, 16'hffff);
      rd(`PMEV_ADDR_FLAGS, 16'h0000);
      $display("enable test done");
      for (k = 0; k < 6; k++) begin
         wr(`PMEV_ADDR_ENABLE, 16'h0400 << k); n0 = nmi_cnt;
         pin[k] = 1'b1; repeat (3) @(negedge CLK_I);
         `CHK(nmi_cnt - n0, 1)
         pin[k] = 1'b0; repeat (3) @(negedge CLK_I);
         `CHK(nmi_cnt - n0, 2)
         `CHK(status[k], 1'b1)
         rd(`PMEV_ADDR_FLAGS, 16'h0004 << k);
         wr(`PMEV_ADDR_ENABLE, 16'h0000);
         rd(`PMEV_ADDR_FLAGS, 16'h0000);
         `CHK(status[k], 1'b0)
      end
      $display("nmi test done");
      wr(`PMEV_ADDR_ENABLE, 16'h2020); pin[3] = 1'b1;
      repeat (3) @(negedge CLK_I);
      `CHK(atn, 1'b1)
      wr(`PMEV_ADDR_ENABLE, 16'h0020);
      rd(`PMEV_ADDR_FLAGS, 16'h0020);
      wr(`PMEV_ADDR_ENABLE, 16'h2000);
      rd(`PMEV_ADDR_FLAGS, 16'h0020);
      `CHK(atn, 1'b0)
      wr(`PMEV_ADDR_ENABLE, 16'h0000);
      rd(`PMEV_ADDR_FLAGS, 16'h0000);
      `CHK(status[3], 1'b1)
      pin[3] = 1'b0;
      $display("attention test done");
      for (k = 0; k < 10; k++) begin
         seed = xs(seed);
         m = (k == 0) ? {29{1'b1}} : seed[28:0];
         cmd = (k == 0) ? 3'h4 : (k == 1) ? 3'h2 : (k == 2) ? 3'h0
               : seed[31:29];
         if (cmd == 3'h4) rot = 1'b1;
         else if (cmd == 3'h0) rot = 1'b0;
         wr(`PMEV_ADDR_SPMIRROR, seed[15:0]);
         wr(`PMEV_ADDR_ICMIRROR, ~seed[15:0]);
         rd(`PMEV_ADDR_SPMIRROR, m[28:13]);
         rd(`PMEV_ADDR_ICMIRROR, exp_ic(m, rot));
      end
      $display("mirror test done");
      stop_test;
   end
endmodule
